// file: amd_consts.vh
// Notes on behaviour
// (RL1) Indirect store: accumulator to pointed byte, 2 cycles
// (RL2) Software keeps pointer upper byte at zero
// (RL3) Exchange swaps accumulator and memory, flags kept
// (RL4) Push stores flags/accumulator at pointer, adds 2
// (RL5) Pop subtracts 2 first, then restores pair
// (RL6) Add immediate into accumulator, all flags updated
// (RL7) Add memory, result to accumulator or memory
// (RL8) Add with carry, result to accumulator or memory
// (RL9) Add carry alone to accumulator or memory
// (RL10) Subtract immediate by two's complement add
// (RL11) Accumulator minus memory into accumulator
// (RL12) Memory minus accumulator back into memory
// (RL13) Subtract with borrow, both operand orders
// (RL14) Subtract carry alone from operand in place
// (RL15) Increment memory byte in place, flags updated
// (RL16) Decrement memory byte in place, flags updated
// (RL17) Clear memory byte, flags kept
// (RL18) Zero flag set when result is zero
// (RL19) Carry is unsigned carry or borrow
// (RL20) Half bit flag is low nibble carry
// (RL21) Signed excess flag on signed overflow
// (RL22) Results truncated to eight bits
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define AMD_OFF_CTRL   8'h00
`define AMD_OFF_OPND   8'h04
`define AMD_OFF_ACC    8'h08
`define AMD_OFF_FLAGS  8'h0c
`define AMD_OFF_SP     8'h10
`define AMD_OFF_MADDR  8'h14
`define AMD_OFF_MDATA  8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AMD_CTRL_BUSY  8
`define AMD_FZ         0
`define AMD_FC         1
`define AMD_FAC        2
`define AMD_FOV        3

// ----------------------------------------------------------------
// Reset values and step sizes
// ----------------------------------------------------------------
`define AMD_ACC_RST    8'h00
`define AMD_SP_RST     8'h00
`define AMD_FLAGS_RST  4'h0
`define AMD_SP_STEP    8'h02
`define AMD_PAIR_HI    8'h01
`define AMD_APB_LAST   2'h2

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define AMD_OP_IDXST   5'h00
`define AMD_OP_XCH     5'h01
`define AMD_OP_PUSH    5'h02
`define AMD_OP_POP     5'h03
`define AMD_OP_ADD_AI  5'h04
`define AMD_OP_ADD_AM  5'h05
`define AMD_OP_ADD_MA  5'h06
`define AMD_OP_ADDC_AM 5'h07
`define AMD_OP_ADDC_MA 5'h08
`define AMD_OP_ADDC_A  5'h09
`define AMD_OP_ADDC_M  5'h0a
`define AMD_OP_SUB_AI  5'h0b
`define AMD_OP_SUB_AM  5'h0c
`define AMD_OP_SUB_MA  5'h0d
`define AMD_OP_SUBC_AM 5'h0e
`define AMD_OP_SUBC_MA 5'h0f
`define AMD_OP_SUBC_A  5'h10
`define AMD_OP_SUBC_M  5'h11
`define AMD_OP_INC_M   5'h12
`define AMD_OP_DEC_M   5'h13
`define AMD_OP_CLR_M   5'h14

`endif

// file: amd_ram.v
`timescale 1ns/1ns
`include "amd_consts.vh"

module amd_ram #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata_reg
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Single port, registered read of the old contents
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_reg <= mem[addr];
    end

endmodule

// file: amd_alu.v
`timescale 1ns/1ns
`include "amd_consts.vh"

module amd_alu #(
    parameter W = 8
) (
    input  wire [W-1:0] x,
    input  wire [W-1:0] y,
    input  wire         sub,
    input  wire         cin,
    output wire [W-1:0] res,
    output wire [3:0]   flags
);

    // Subtraction adds the inverted operand and inverted borrow
    wire [W-1:0] yy  = sub ? ~y : y;
    wire         ci  = sub ? ~cin : cin;
    wire [W:0]   sum = {1'b0, x} + {1'b0, yy} + {{W{1'b0}}, ci};
    wire [4:0]   nib = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci};

    assign res = sum[W-1:0];                                     // [RL22]
    assign flags[`AMD_FZ]  = (sum[W-1:0] == {W{1'b0}});          // [RL18]
    assign flags[`AMD_FC]  = sum[W] ^ sub;                       // [RL19]
    assign flags[`AMD_FAC] = nib[4] ^ sub;                       // [RL20]
    // Same operand signs but result sign differs
    assign flags[`AMD_FOV] = (x[W-1] == yy[W-1]) &
                             (sum[W-1] != x[W-1]);               // [RL21]

endmodule

// file: amd_datapath.v
`timescale 1ns/1ns
`include "amd_consts.vh"

module amd_datapath #(
    parameter AW = 8
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr
);

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    localparam ST_IDLE  = 2'h0;
    localparam ST_ISSUE = 2'h1;
    localparam ST_DATA  = 2'h2;
    localparam ST_POP2  = 2'h3;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [4:0]  op_reg;
    reg  [7:0]  addr_reg;
    reg  [7:0]  imm_reg;
    reg  [7:0]  acc_reg;
    reg  [7:0]  acc_next;
    reg  [3:0]  flags_reg;
    reg  [3:0]  flags_next;
    reg  [7:0]  sp_reg;
    reg  [7:0]  sp_next;
    reg  [7:0]  maddr_reg;
    reg  [1:0]  ph_reg;
    reg  [31:0] prdata_reg;
    reg  [31:0] rd_mux;
    reg         mapped;

    reg         mem_we;
    reg  [7:0]  mem_addr;
    reg  [7:0]  mem_wdata;
    wire [7:0]  mem_rdata;

    reg  [7:0]  alu_x;
    reg  [7:0]  alu_y;
    reg         alu_sub;
    reg         alu_cin;
    wire [7:0]  alu_res;
    wire [3:0]  alu_flags;

    wire        busy;
    wire        access;
    wire        apb_wr;
    wire        to_mem;
    wire        acc_only;
    wire        carry;

    assign busy   = (state_reg != ST_IDLE);
    assign access = psel & penable;
    assign carry  = flags_reg[`AMD_FC];

    // ------------------------------------------------------------
    // APB slave: three access cycles, stalled while busy
    // ------------------------------------------------------------
    assign pready  = access & ~busy & (ph_reg == `AMD_APB_LAST);
    assign pslverr = pready & ~mapped;
    assign prdata  = prdata_reg;
    assign apb_wr  = pready & pwrite & mapped;

    // Read data selection and address decode
    always @* begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `AMD_OFF_CTRL: begin
                rd_mux[`AMD_CTRL_BUSY] = busy;
                rd_mux[4:0] = op_reg;
            end
            `AMD_OFF_OPND: begin
                rd_mux[15:0] = {imm_reg, addr_reg};
            end
            `AMD_OFF_ACC: begin
                rd_mux[7:0] = acc_reg;
            end
            `AMD_OFF_FLAGS: begin
                rd_mux[3:0] = flags_reg;
            end
            `AMD_OFF_SP: begin
                rd_mux[7:0] = sp_reg;
            end
            `AMD_OFF_MADDR: begin
                rd_mux[7:0] = maddr_reg;
            end
            `AMD_OFF_MDATA: begin
                rd_mux[7:0] = mem_rdata;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Access phase counter and read data capture
    always @(posedge clk) begin
        if (!nrst) begin
            ph_reg     <= 2'h0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            if (!access || pready) begin
                ph_reg <= 2'h0;
            end else if (!busy) begin
                ph_reg <= ph_reg + 2'h1;
            end
            if (access && !busy && ph_reg == 2'h1) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Operation classes
    // ------------------------------------------------------------
    assign acc_only = (op_reg == `AMD_OP_ADD_AI) |
                      (op_reg == `AMD_OP_SUB_AI) |
                      (op_reg == `AMD_OP_ADDC_A) |
                      (op_reg == `AMD_OP_SUBC_A);

    assign to_mem = (op_reg == `AMD_OP_ADD_MA)  |
                    (op_reg == `AMD_OP_ADDC_MA) |
                    (op_reg == `AMD_OP_ADDC_M)  |
                    (op_reg == `AMD_OP_SUB_MA)  |
                    (op_reg == `AMD_OP_SUBC_MA) |
                    (op_reg == `AMD_OP_SUBC_M)  |
                    (op_reg == `AMD_OP_INC_M)   |
                    (op_reg == `AMD_OP_DEC_M);

    // ------------------------------------------------------------
    // ALU operand selection
    // ------------------------------------------------------------
    always @* begin
        alu_x   = acc_reg;
        alu_y   = mem_rdata;
        alu_sub = 1'b0;
        alu_cin = 1'b0;
        case (op_reg)
            `AMD_OP_ADD_AI: begin
                alu_y = imm_reg;                                 // [RL6]
            end
            `AMD_OP_ADD_AM, `AMD_OP_ADD_MA: begin
                alu_y = mem_rdata;                               // [RL7]
            end
            `AMD_OP_ADDC_AM, `AMD_OP_ADDC_MA: begin
                alu_cin = carry;                                 // [RL8]
            end
            `AMD_OP_ADDC_A: begin
                alu_y   = 8'h00;
                alu_cin = carry;                                 // [RL9]
            end
            `AMD_OP_ADDC_M: begin
                alu_x   = mem_rdata;
                alu_y   = 8'h00;
                alu_cin = carry;                                 // [RL9]
            end
            `AMD_OP_SUB_AI: begin
                alu_y   = imm_reg;
                alu_sub = 1'b1;                                  // [RL10]
            end
            `AMD_OP_SUB_AM: begin
                alu_sub = 1'b1;                                  // [RL11]
            end
            `AMD_OP_SUB_MA: begin
                alu_x   = mem_rdata;
                alu_y   = acc_reg;
                alu_sub = 1'b1;                                  // [RL12]
            end
            `AMD_OP_SUBC_AM: begin
                alu_sub = 1'b1;
                alu_cin = carry;                                 // [RL13]
            end
            `AMD_OP_SUBC_MA: begin
                alu_x   = mem_rdata;
                alu_y   = acc_reg;
                alu_sub = 1'b1;
                alu_cin = carry;                                 // [RL13]
            end
            `AMD_OP_SUBC_A: begin
                alu_y   = 8'h00;
                alu_sub = 1'b1;
                alu_cin = carry;                                 // [RL14]
            end
            `AMD_OP_SUBC_M: begin
                alu_x   = mem_rdata;
                alu_y   = 8'h00;
                alu_sub = 1'b1;
                alu_cin = carry;                                 // [RL14]
            end
            `AMD_OP_INC_M: begin
                alu_x   = mem_rdata;
                alu_y   = 8'h00;
                alu_cin = 1'b1;                                  // [RL15]
            end
            `AMD_OP_DEC_M: begin
                alu_x   = mem_rdata;
                alu_y   = 8'h00;
                alu_sub = 1'b1;
                alu_cin = 1'b1;                                  // [RL16]
            end
            default: begin
                alu_x = acc_reg;
            end
        endcase
    end

    amd_alu #(
        .W     (8)
    ) u_alu (
        .x     (alu_x),
        .y     (alu_y),
        .sub   (alu_sub),
        .cin   (alu_cin),
        .res   (alu_res),
        .flags (alu_flags)
    );

    // ------------------------------------------------------------
    // Sequencer and memory port control
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        acc_next   = acc_reg;
        flags_next = flags_reg;
        sp_next    = sp_reg;
        mem_we     = 1'b0;
        mem_addr   = maddr_reg;
        mem_wdata  = pwdata[7:0];
        case (state_reg)
            ST_IDLE: begin
                if (apb_wr && paddr == `AMD_OFF_MDATA) begin
                    mem_we = 1'b1;
                end
                if (apb_wr && paddr == `AMD_OFF_CTRL) begin
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                state_next = ST_IDLE;
                if (op_reg == `AMD_OP_PUSH) begin
                    mem_we     = 1'b1;
                    mem_addr   = sp_reg;
                    mem_wdata  = acc_reg;                        // [RL4]
                    state_next = ST_DATA;
                end else if (op_reg == `AMD_OP_POP) begin
                    sp_next    = sp_reg - `AMD_SP_STEP;          // [RL5]
                    mem_addr   = sp_reg - `AMD_SP_STEP;
                    state_next = ST_DATA;
                end else if (op_reg == `AMD_OP_CLR_M) begin
                    mem_we    = 1'b1;
                    mem_addr  = addr_reg;
                    mem_wdata = 8'h00;                           // [RL17]
                end else if (acc_only) begin
                    acc_next   = alu_res;
                    flags_next = alu_flags;
                end else if (op_reg <= `AMD_OP_DEC_M) begin
                    // Fetch the operand byte or the pointer low byte
                    mem_addr   = addr_reg;                       // [RL1]
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                state_next = ST_IDLE;
                case (op_reg)
                    `AMD_OP_IDXST: begin
                        // Only the pointer low byte picks the target
                        mem_we    = 1'b1;
                        mem_addr  = mem_rdata;                   // [RL1] [RL2]
                        mem_wdata = acc_reg;
                    end
                    `AMD_OP_XCH: begin
                        mem_we    = 1'b1;
                        mem_addr  = addr_reg;
                        mem_wdata = acc_reg;                     // [RL3]
                        acc_next  = mem_rdata;                   // [RL3]
                    end
                    `AMD_OP_PUSH: begin
                        mem_we    = 1'b1;
                        mem_addr  = sp_reg + `AMD_PAIR_HI;
                        mem_wdata = {4'h0, flags_reg};           // [RL4]
                        sp_next   = sp_reg + `AMD_SP_STEP;       // [RL4]
                    end
                    `AMD_OP_POP: begin
                        acc_next   = mem_rdata;                  // [RL5]
                        mem_addr   = sp_reg + `AMD_PAIR_HI;
                        state_next = ST_POP2;
                    end
                    default: begin
                        flags_next = alu_flags;
                        if (to_mem) begin
                            mem_we    = 1'b1;
                            mem_addr  = addr_reg;
                            mem_wdata = alu_res;                 // [RL7] [RL22]
                        end else begin
                            acc_next = alu_res;                  // [RL7] [RL22]
                        end
                    end
                endcase
            end
            ST_POP2: begin
                flags_next = mem_rdata[3:0];                     // [RL5]
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    amd_ram #(
        .AW        (AW),
        .DW        (8)
    ) u_ram (
        .clk       (clk),
        .we        (mem_we),
        .addr      (mem_addr[AW-1:0]),
        .wdata     (mem_wdata),
        .rdata_reg (mem_rdata)
    );

    // ------------------------------------------------------------
    // State, software-visible registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            op_reg    <= `AMD_OP_IDXST;
            addr_reg  <= 8'h00;
            imm_reg   <= 8'h00;
            acc_reg   <= `AMD_ACC_RST;
            flags_reg <= `AMD_FLAGS_RST;
            sp_reg    <= `AMD_SP_RST;
            maddr_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            // Software writes land only while idle
            if (apb_wr && paddr == `AMD_OFF_CTRL) begin
                op_reg <= pwdata[4:0];
            end
            if (apb_wr && paddr == `AMD_OFF_OPND) begin
                addr_reg <= pwdata[7:0];
                imm_reg  <= pwdata[15:8];
            end
            if (apb_wr && paddr == `AMD_OFF_ACC) begin
                acc_reg <= pwdata[7:0];
            end else begin
                acc_reg <= acc_next;
            end
            if (apb_wr && paddr == `AMD_OFF_FLAGS) begin
                flags_reg <= pwdata[3:0];
            end else begin
                flags_reg <= flags_next;
            end
            if (apb_wr && paddr == `AMD_OFF_SP) begin
                sp_reg <= pwdata[7:0];
            end else begin
                sp_reg <= sp_next;
            end
            if (apb_wr && paddr == `AMD_OFF_MADDR) begin
                maddr_reg <= pwdata[7:0];
            end
        end
    end

endmodule

// file: amd_ref_alu.sv
`timescale 1ns/1ns
// ----------------------------------------
// Reference adder for expected results
// ----------------------------------------
module amd_ref_alu (
    input  logic [7:0] x,
    input  logic [7:0] y,
    input  logic       sub,
    input  logic       cin,
    output logic [7:0] res,
    output logic [3:0] flags
);
    logic [8:0] full;
    logic [4:0] low;

    // Subtract counts borrows, add counts carries
    always_comb begin
        full = sub ? {1'b0, x} - y - cin : {1'b0, x} + y + cin;
        low = sub ? {1'b0, x[3:0]} - y[3:0] - cin : {1'b0, x[3:0]} + y[3:0] + cin;
        res = full[7:0];
        flags[0] = (res == 8'h00);
        flags[1] = full[8];
        flags[2] = low[4];
        flags[3] = (x[7] == (y[7] ^ sub)) && (res[7] != x[7]);
    end
endmodule

// file: amd_dp_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bus handshake and read data checks
// ----------------------------------------
module amd_dp_assertions (
    input logic        clk,
    input logic        nrst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Replies only inside an access phase
    property p_err_rdy;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    property p_rdy_sel;
        pready |-> psel && penable;
    endproperty
    a_rdy_sel: assert property (p_rdy_sel) else $error("ready outside access");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    // Two wait states, then a bounded wait
    property p_wait;
        psel && penable && !$past(penable) |-> !pready ##1 !pready;
    endproperty
    a_wait: assert property (p_wait) else $error("ready too early");
    property p_bound;
        psel && penable && !pready |-> ##[1:8] pready;
    endproperty
    a_bound: assert property (p_bound) else $error("ready too late");
    // Address decode
    property p_unmap;
        pready && paddr > 8'h18 |-> pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not flagged");
    property p_map;
        pready && paddr[1:0] == 2'h0 && paddr <= 8'h18 |-> !pslverr;
    endproperty
    a_map: assert property (p_map) else $error("mapped flagged");
    property p_rd_err;
        pready && !pwrite && pslverr |-> prdata == 32'h0;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not zero");
    // Byte wide values except the control and operand registers
    property p_trunc;
        pready && !pwrite && paddr != 8'h00 && paddr != 8'h04 |-> prdata[31:8] == 24'h0;
    endproperty
    a_trunc: assert property (p_trunc) else $error("upper bits set");
endmodule

// file: tb_amd_datapath.sv
`timescale 1ns/1ns
`include "amd_consts.vh"
module tb_amd_datapath;
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic [7:0]  rx;
    logic [7:0]  ry;
    logic        rsub;
    logic        rcin;
    wire  [7:0]  rres;
    wire  [3:0]  rflg;
    logic [31:0] rd;
    logic        er;
    int          n_fail;
    int          n_tests;
    int          cyc;

    amd_datapath #(.AW(8)) u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    amd_ref_alu u_ref (.x(rx), .y(ry), .sub(rsub), .cin(rcin), .res(rres), .flags(rflg));

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task wrap_up();
        $display("Compares %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One transfer, held until ready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Ready, read data and error are taken at the rising edge itself
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("BAD %0t no ready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0, d});
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, {24'h0, e}, m);
    endtask
    task mwr(input logic [7:0] a, input logic [7:0] d);
        wr(`AMD_OFF_MADDR, {8'h0, a});
        wr(`AMD_OFF_MDATA, {8'h0, d});
    endtask
    task mchk(input logic [7:0] a, input logic [7:0] e, input string m);
        wr(`AMD_OFF_MADDR, {8'h0, a});
        rdc(`AMD_OFF_MDATA, e, m);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs();
        rdc(`AMD_OFF_ACC, 8'h00, "acc rst");
        rdc(`AMD_OFF_FLAGS, 8'h00, "flags rst");
        rdc(`AMD_OFF_SP, 8'h00, "sp rst");
        apb(1'b1, 8'h1c, 32'h0000_00ff);
        chk({31'h0, er}, 32'h1, "unmapped wr");
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped rd");
        chk(rd, 32'h0, "unmapped data");
        $display("test regs done");
    endtask

    task t_alu();
        logic [7:0] a;
        logic [7:0] m;
        logic [7:0] im;
        logic [4:0] o;
        logic       c;
        logic       md;
        for (int s = 0; s < 2; s++) begin
            a = s ? 8'h7f : 8'h88;
            m = s ? 8'h00 : 8'hff;
            im = s ? 8'h81 : 8'h78;
            c = (s == 0);
            for (int i = 4; i < 20; i++) begin
                o = i[4:0];
                md = o inside {5'h06, 5'h08, 5'h0a, 5'h0d, 5'h0f, 5'h11, 5'h12, 5'h13};
                rx = md ? m : a;
                ry = (o == 5'h04 || o == 5'h0b) ? im : (md ? a : m);
                if (o inside {5'h09, 5'h0a, 5'h10, 5'h11})
                    ry = 8'h00;
                if (o >= 5'h12)
                    ry = 8'h01;
                rsub = o inside {[5'h0b:5'h11], 5'h13};
                rcin = c && (o inside {[5'h07:5'h0a], [5'h0e:5'h11]});
                wr(`AMD_OFF_ACC, {8'h0, a});
                wr(`AMD_OFF_FLAGS, {12'h0, {4{c}}});
                mwr(8'h20, m);
                wr(`AMD_OFF_OPND, {im, 8'h20});
                wr(`AMD_OFF_CTRL, {11'h0, o});
                rdc(`AMD_OFF_ACC, md ? a : rres, "alu acc");
                rdc(`AMD_OFF_FLAGS, {4'h0, rflg}, "alu flags");
                mchk(8'h20, md ? rres : m, "alu mem");
                rdc(`AMD_OFF_CTRL, {3'h0, o}, "ctrl");
            end
        end
        $display("test alu done");
    endtask

    task t_move();
        mwr(8'h30, 8'h5b);
        mwr(8'h31, 8'h00);
        mwr(8'h5b, 8'h00);
        wr(`AMD_OFF_ACC, 16'h00a5);
        wr(`AMD_OFF_FLAGS, 16'h000f);
        wr(`AMD_OFF_OPND, 16'h0030);
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_IDXST});
        mchk(8'h5b, 8'ha5, "ind store");
        rdc(`AMD_OFF_FLAGS, 8'h0f, "ind flags");
        wr(`AMD_OFF_ACC, 16'h003c);
        mwr(8'h20, 8'hc3);
        wr(`AMD_OFF_FLAGS, 16'h000a);
        wr(`AMD_OFF_OPND, 16'h0020);
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_XCH});
        rdc(`AMD_OFF_ACC, 8'hc3, "xch acc");
        mchk(8'h20, 8'h3c, "xch mem");
        rdc(`AMD_OFF_FLAGS, 8'h0a, "xch flags");
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_CLR_M});
        mchk(8'h20, 8'h00, "clr mem");
        rdc(`AMD_OFF_FLAGS, 8'h0a, "clr flags");
        wr(`AMD_OFF_SP, 16'h0040);
        wr(`AMD_OFF_ACC, 16'h009a);
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_PUSH});
        mchk(8'h40, 8'h9a, "push acc");
        mchk(8'h41, 8'h0a, "push flags");
        rdc(`AMD_OFF_SP, 8'h42, "push sp");
        rdc(`AMD_OFF_FLAGS, 8'h0a, "push keep");
        wr(`AMD_OFF_ACC, 16'h0011);
        wr(`AMD_OFF_FLAGS, 16'h0005);
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_PUSH});
        rdc(`AMD_OFF_SP, 8'h44, "push2 sp");
        wr(`AMD_OFF_ACC, 16'h0000);
        wr(`AMD_OFF_FLAGS, 16'h0000);
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_POP});
        rdc(`AMD_OFF_SP, 8'h42, "pop sp");
        rdc(`AMD_OFF_ACC, 8'h11, "pop acc");
        rdc(`AMD_OFF_FLAGS, 8'h05, "pop flags");
        wr(`AMD_OFF_CTRL, {11'h0, `AMD_OP_POP});
        rdc(`AMD_OFF_SP, 8'h40, "pop2 sp");
        rdc(`AMD_OFF_ACC, 8'h9a, "pop2 acc");
        rdc(`AMD_OFF_FLAGS, 8'h0a, "pop2 flags");
        $display("test move done");
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_alu();
        t_move();
        wrap_up();
    end
endmodule

bind amd_datapath amd_dp_assertions u_chk (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
